// File: core/ar_timer_pkg.sv
// Purpose: shared constants for the auto-reload timer block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: printed offsets are register indices, byte address is 4x index
package ar_timer_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int PSC_W = 7;
  localparam int TAP_W = 3;
  localparam int SRC_W = 2;

  // register indices
  localparam logic [7:0] IDX_MODE = 8'hE5;
  localparam logic [7:0] IDX_FLAGS = 8'hE6;
  localparam logic [7:0] IDX_CLKSEL = 8'hE7;
  localparam logic [7:0] IDX_RELOAD = 8'hE9;
  localparam logic [7:0] IDX_COMPARE = 8'hEA;
  localparam logic [7:0] IDX_WINDOW = 8'hEB;
  localparam int IDX_SHIFT = 2;

  // timer_mode_control fields
  localparam int MODE_LOAD_BIT = 7;
  localparam int MODE_EN_BIT = 6;
  localparam int MODE_COMPARE_IRQ_ENABLE_BIT = 3;
  localparam int MODE_OVERFLOW_IRQ_ENABLE_BIT = 2;
  localparam logic [REG_W-1:0] MODE_RESET = 8'h00;

  // timer_event_flags fields
  localparam int FLAG_CPF_BIT = 1;
  localparam int FLAG_OVF_BIT = 0;

  // clock_and_divider_select fields
  localparam int TAP_LSB = 5;
  localparam int SRC_LSB = 0;
  localparam logic [SRC_W-1:0] SRC_INT = 2'h0;
  localparam logic [SRC_W-1:0] SRC_INT_DIV3 = 2'h1;
  localparam int DIV3_RATIO = 3;

  localparam logic [REG_W-1:0] COUNT_MAX = 8'hFF;
  localparam logic [REG_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [REG_W-1:0] CONFIG_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: core/auto_reload_timer.sv
// Purpose: 8-bit auto-reload up-counter with prescaler and compare
// Assumes: aclk is the internal clock, registers over AXI4-Lite
// Notes: two interrupt request levels, no interrupt logic beyond masks
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module auto_reload_timer
  import ar_timer_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic overflow_irq,
  output logic compare_irq
);

  localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'(IDX_MODE) << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] A_FLAGS = ADDR_W'(IDX_FLAGS) << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] A_CLKSEL = ADDR_W'(IDX_CLKSEL) << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] A_RELOAD = ADDR_W'(IDX_RELOAD) << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] A_COMPARE =
    ADDR_W'(IDX_COMPARE) << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] A_WINDOW = ADDR_W'(IDX_WINDOW) << IDX_SHIFT;

  // write channel state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [REG_W-1:0] w_byte;
  logic w_lane;
  logic wr_fire;
  logic wr_hit;

  // register contents
  logic count_enable;
  logic compare_irq_enable;
  logic overflow_irq_enable;
  logic overflow_flag;
  logic compare_flag;
  logic [TAP_W-1:0] tap_select;
  logic [SRC_W-1:0] clock_source_select;
  logic [REG_W-1:0] reload_value;
  logic [REG_W-1:0] compare_value;

  // timer core
  logic [REG_W-1:0] up_counter;
  logic [PSC_W-1:0] timer_prescaler;
  logic div3_tick;
  logic src_tick;
  logic tap_hit;
  logic cnt_tick;
  logic [REG_W:0] tap_onehot;
  logic [PSC_W-1:0] tap_mask;
  logic win_wr;
  logic load_command;
  logic wraps;
  logic any_load;
  logic [REG_W-1:0] next_counter;

  // AXI4-Lite write side
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= '0;
      w_lane <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[REG_W-1:0];
      w_lane <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    case (aw_addr)
      A_MODE, A_FLAGS, A_CLKSEL, A_RELOAD, A_COMPARE, A_WINDOW: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // a write without byte lane 0 carries no register data
  function automatic logic wr_to(input logic [ADDR_W-1:0] a);
    wr_to = wr_fire && w_lane && (aw_addr == a);
  endfunction

  assign win_wr = wr_to(A_WINDOW);
  assign load_command = wr_to(A_MODE) && w_byte[MODE_LOAD_BIT];

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {count_enable, compare_irq_enable, overflow_irq_enable} <= '0;
    end else if (wr_to(A_MODE)) begin
      count_enable <= w_byte[MODE_EN_BIT];
      compare_irq_enable <= w_byte[MODE_COMPARE_IRQ_ENABLE_BIT];
      overflow_irq_enable <= w_byte[MODE_OVERFLOW_IRQ_ENABLE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tap_select <= CONFIG_RESET[TAP_W-1:0];
      clock_source_select <= CONFIG_RESET[SRC_W-1:0];
    end else if (wr_to(A_CLKSEL)) begin
      tap_select <= w_byte[TAP_LSB +: TAP_W];
      clock_source_select <= w_byte[SRC_LSB +: SRC_W];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_value <= CONFIG_RESET;
      compare_value <= CONFIG_RESET;
    end else begin
      if (wr_to(A_RELOAD)) begin
        reload_value <= w_byte;
      end
      if (wr_to(A_COMPARE)) begin
        compare_value <= w_byte;
      end
    end
  end

  // clock source and prescaler
  rate_divider #(
    .RATIO(DIV3_RATIO)
  ) u_div3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(1'b1),
    .tick(div3_tick)
  );

  always_comb begin
    case (clock_source_select)
      SRC_INT: src_tick = 1'b1;
      SRC_INT_DIV3: src_tick = div3_tick;
      default: src_tick = 1'b0;
    endcase
  end

  // tap n fires when the low n prescaler bits roll over
  assign tap_onehot = (REG_W+1)'(1) << tap_select;
  assign tap_mask = PSC_W'(tap_onehot - (REG_W+1)'(1));
  assign tap_hit = (timer_prescaler & tap_mask) == tap_mask;
  assign cnt_tick = count_enable && src_tick && tap_hit;

  assign wraps = cnt_tick && (up_counter == COUNT_MAX);
  assign any_load = win_wr || load_command || wraps;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_prescaler <= '0;
    end else if (any_load) begin
      timer_prescaler <= '0;
    end else if (count_enable && src_tick) begin
      timer_prescaler <= timer_prescaler + PSC_W'(1);
    end
  end

  // counter, window write first, then load command, then counting
  always_comb begin
    if (win_wr) begin
      next_counter = w_byte;
    end else if (load_command) begin
      next_counter = reload_value;
    end else if (wraps) begin
      next_counter = reload_value;
    end else if (cnt_tick) begin
      next_counter = up_counter + REG_W'(1);
    end else begin
      next_counter = up_counter;
    end
  end

  // window is the counter itself, so reset only clears the counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_counter <= ZERO_BYTE;
    end else begin
      up_counter <= next_counter;
    end
  end

  // event flags, a hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
      compare_flag <= 1'b0;
    end else begin
      if (wraps && !win_wr) begin
        overflow_flag <= 1'b1;
      end else if (wr_to(A_FLAGS) && !w_byte[FLAG_OVF_BIT]) begin
        overflow_flag <= 1'b0;
      end
      if (cnt_tick && !any_load && next_counter == compare_value) begin
        compare_flag <= 1'b1;
      end else if (wr_to(A_FLAGS) && !w_byte[FLAG_CPF_BIT]) begin
        compare_flag <= 1'b0;
      end
    end
  end

  assign overflow_irq = overflow_flag && overflow_irq_enable;
  assign compare_irq = compare_flag && compare_irq_enable;

  // AXI4-Lite read side, one cycle to answer
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      case (s_axi_araddr)
        A_MODE: begin
          s_axi_rdata[MODE_EN_BIT] <= count_enable;
          s_axi_rdata[MODE_COMPARE_IRQ_ENABLE_BIT] <= compare_irq_enable;
          s_axi_rdata[MODE_OVERFLOW_IRQ_ENABLE_BIT] <= overflow_irq_enable;
        end
        A_FLAGS: begin
          s_axi_rdata[FLAG_CPF_BIT] <= compare_flag;
          s_axi_rdata[FLAG_OVF_BIT] <= overflow_flag;
        end
        A_CLKSEL: begin
          s_axi_rdata[TAP_LSB +: TAP_W] <= tap_select;
          s_axi_rdata[SRC_LSB +: SRC_W] <= clock_source_select;
        end
        A_RELOAD: s_axi_rdata[REG_W-1:0] <= reload_value;
        A_COMPARE: s_axi_rdata[REG_W-1:0] <= compare_value;
        A_WINDOW: s_axi_rdata[REG_W-1:0] <= up_counter;
        default: s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wrap;
    cnt_tick && up_counter == COUNT_MAX && !win_wr && !load_command;
  endsequence

  sequence s_plain_step;
    cnt_tick && up_counter != COUNT_MAX && !win_wr && !load_command;
  endsequence

  sequence s_idle;
    !count_enable && !win_wr && !load_command;
  endsequence

  a_step_by_one: assert property (
    s_plain_step |=> up_counter == $past(up_counter) + REG_W'(1))
    else $error("counter did not step by one");

  a_wrap_reload: assert property (
    s_wrap |=> up_counter == $past(reload_value) && timer_prescaler == '0)
    else $error("overflow did not reload counter");

  a_wrap_flag: assert property (
    s_wrap |=> overflow_flag)
    else $error("overflow flag not set on wrap");

  a_stop_freeze: assert property (
    s_idle |=> $stable(up_counter) && $stable(timer_prescaler))
    else $error("stopped timer moved");

  a_window_load: assert property (
    win_wr |=> up_counter == $past(w_byte) && timer_prescaler == '0)
    else $error("window write not copied to counter");

  a_cmd_load: assert property (
    load_command && !win_wr |=> up_counter == $past(reload_value)
      && timer_prescaler == '0)
    else $error("load command did not load and clear");

  a_ovf_request: assert property (
    $rose(overflow_flag) && overflow_irq_enable |-> overflow_irq)
    else $error("overflow request missing");

  a_cmp_request: assert property (
    compare_flag && !compare_irq_enable |-> !compare_irq)
    else $error("masked compare request raised");

  a_flag_sticky: assert property (
    overflow_flag && !(wr_fire && w_lane && aw_addr == A_FLAGS)
      |=> overflow_flag)
    else $error("overflow flag lost without clear");

  a_cmp_flag_set: assert property (
    s_plain_step and (up_counter + REG_W'(1) == compare_value)
      |=> compare_flag)
    else $error("compare match not flagged");

  a_rsvd_hold: assert property (
    clock_source_select[1] |-> !cnt_tick)
    else $error("reserved source produced a tick");

  a_mode_reset: assert property (
    $rose(aresetn) |-> !count_enable && !overflow_irq && !compare_irq)
    else $error("mode not cleared by reset");

endmodule // auto_reload_timer

// File: core/rate_divider.sv
// Purpose: one-cycle enable pulse every RATIO clocks
// Assumes: single clock, synchronous active-low reset
// Notes: used to derive the internal clock divided by three
`timescale 1ns/1ps
module rate_divider #(
  parameter int RATIO = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic tick
);

  localparam int CW = $clog2(RATIO);
  localparam logic [CW-1:0] LAST = CW'(RATIO - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] phase;

  // free running so the divided rate stays in step with the base clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= '0;
    end else if (run) begin
      phase <= (phase == LAST) ? '0 : phase + ONE;
    end
  end

  assign tick = run && (phase == LAST);

endmodule // rate_divider

// File: sim/auto_reload_timer_tb.sv
// Purpose: register-level self-checking bench for the auto-reload timer
// Assumes: AXI4-Lite slave answers by handshake, 40 MHz aclk
// Notes: live counts are checked as ranges, bus latency is not fixed
`timescale 1ns/1ps
module auto_reload_timer_tb;
  import ar_timer_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W/8-1:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic overflow_irq;
  logic compare_irq;
  logic [31:0] d;
  logic [1:0] r;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int lo;
  int hi;
  int dv;

  always #12.5 aclk = ~aclk;

  auto_reload_timer u_auto_reload_timer (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .overflow_irq(overflow_irq), .compare_irq(compare_irq)
  );

  function automatic logic [ADDR_W-1:0] ad(input logic [7:0] idx);
    return ADDR_W'(idx) << IDX_SHIFT;
  endfunction

  task automatic summarize();
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input logic [31:0] got, input int l, input int h);
    logic ok;
    ok = (got >= l) && (got <= h);
    comparisons++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: got %h outside %0d..%0d", $time, got,
        l, h);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] v,
                    output logic [1:0] rsp);
    logic a;
    logic w;
    logic ta;
    logic tw;
    @(posedge aclk);
    awaddr <= ad(idx);
    wdata <= {24'h0, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      #1;
      a = awvalid && awready;
      w = wvalid && wready;
      @(posedge aclk);
      if (a) begin
        awvalid <= 1'b0;
        ta = 1'b1;
      end
      if (w) begin
        wvalid <= 1'b0;
        tw = 1'b1;
      end
    end
    do begin
      #1;
      a = bvalid;
      rsp = bresp;
      @(posedge aclk);
    end while (a !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] v,
                    output logic [1:0] rsp);
    logic a;
    @(posedge aclk);
    araddr <= ad(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      #1;
      a = arready;
      @(posedge aclk);
    end while (a !== 1'b1);
    arvalid <= 1'b0;
    do begin
      #1;
      a = rvalid;
      v = rdata;
      rsp = rresp;
      @(posedge aclk);
    end while (a !== 1'b1);
    rready <= 1'b0;
  endtask

  // write to a mapped register, response must be okay
  task automatic wo(input logic [7:0] idx, input logic [7:0] v);
    logic [1:0] rsp;
    wr(idx, v, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  task automatic rv(input logic [7:0] idx, output logic [31:0] v);
    logic [1:0] rsp;
    rd(idx, v, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  // ceiling well above the roughly 1900 cycles the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rv(IDX_MODE, d); chk(d, 32'h0);
    rv(IDX_WINDOW, d); chk(d, 32'h0);
    rv(IDX_FLAGS, d); chk(d, 32'h0);
    #1 chk({30'h0, overflow_irq, compare_irq}, 32'h0);
    rd(8'hE8, d, r); chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'hE8, 8'h55, r); chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wo(IDX_WINDOW, 8'h5A);
    repeat (20) @(posedge aclk);
    rv(IDX_WINDOW, d); chk(d, 32'h5A);
    wo(IDX_RELOAD, 8'hF0);
    wo(IDX_MODE, 8'h80);
    rv(IDX_WINDOW, d); chk(d, 32'hF0);
    rv(IDX_MODE, d); chk(d, 32'h0);
    // slowest tap: a cleared prescaler cannot tick within a few cycles
    wo(IDX_CLKSEL, 8'hE0);
    wo(IDX_MODE, 8'h40);
    wo(IDX_WINDOW, 8'h80);
    rv(IDX_WINDOW, d); chk(d, 32'h80);
    wo(IDX_MODE, 8'h00);
    wo(IDX_CLKSEL, 8'h00);
    wo(IDX_FLAGS, 8'h00);
    wo(IDX_RELOAD, 8'h20);
    wo(IDX_COMPARE, 8'h22);
    wo(IDX_WINDOW, 8'hFE);
    wo(IDX_MODE, 8'h4C);
    repeat (8) @(posedge aclk);
    wo(IDX_MODE, 8'h0C);
    rv(IDX_FLAGS, d); chk(d, 32'h3);
    rv(IDX_WINDOW, d); chk_range(d, 8'h21, 8'h30);
    #1 chk({30'h0, overflow_irq, compare_irq}, 32'h3);
    wo(IDX_MODE, 8'h00);
    #1 chk({30'h0, overflow_irq, compare_irq}, 32'h0);
    wo(IDX_FLAGS, 8'hFF);
    rv(IDX_FLAGS, d); chk(d, 32'h3);
    wo(IDX_FLAGS, 8'h02);
    rv(IDX_FLAGS, d); chk(d, 32'h2);
    wo(IDX_FLAGS, 8'h00);
    rv(IDX_FLAGS, d); chk(d, 32'h0);
    // every tap on the plain clock, then div-3 and the reserved codes
    for (int i = 0; i < 11; i++) begin
      logic [2:0] n;
      logic [1:0] s;
      n = (i < 8) ? 3'(i) : 3'h1;
      s = (i < 8) ? 2'h0 : 2'(i - 7);
      dv = (s == SRC_INT) ? (1 << n) : (s == SRC_INT_DIV3) ? (6) : 0;
      lo = (dv == 0) ? 0 : (128 / dv) - 1;
      hi = (dv == 0) ? 0 : (136 / dv) + 1;
      wo(IDX_MODE, 8'h00);
      wo(IDX_CLKSEL, {n, 3'h0, s});
      wo(IDX_WINDOW, 8'h00);
      wo(IDX_MODE, 8'h40);
      repeat (128) @(posedge aclk);
      wo(IDX_MODE, 8'h00);
      rv(IDX_WINDOW, d); chk_range(d, lo, hi);
    end
    // start as software should: reload first, then load with enable
    wo(IDX_CLKSEL, 8'h00);
    wo(IDX_FLAGS, 8'h00);
    wo(IDX_COMPARE, 8'hFE);
    wo(IDX_RELOAD, 8'hFC);
    wo(IDX_MODE, 8'hCC);
    repeat (8) @(posedge aclk);
    wo(IDX_MODE, 8'h00);
    rv(IDX_FLAGS, d); chk(d, 32'h3);
    rv(IDX_WINDOW, d); chk_range(d, 8'hFC, 8'hFF);
    summarize();
  end
endmodule // auto_reload_timer_tb
